// ===== shared/bsc_defs.svh
// Function
// RULE_01: Indirect call: Z to PC, upper bits zero.
// RULE_02: Extended indirect call: high bits from register.
// RULE_03: Equal compare skips the next instruction.
// RULE_04: Register bit clear skips next instruction.
// RULE_05: Register bit set skips next instruction.
// RULE_06: I/O bit clear skips, two to four.
// RULE_07: I/O bit set skips, two to four.
// RULE_08: Flag set branch jumps offset plus one.
// RULE_09: Flag clear branch jumps, else falls through.
// RULE_10: Signed greater-or-equal when N xor V zero.
// RULE_11: Signed less-than when N xor V one.
// RULE_12: Carry clear and same-or-higher test carry zero.
// RULE_13: Half-carry branches test the H flag.
// RULE_14: Interrupt branches test the global enable flag.
// RULE_15: Overflow branches test the V flag.
// RULE_16: Transfer branches test the T flag.
// RULE_17: Zero, carry, lower, sign branches test Z/C/N.
// RULE_18: Compares update flags, write no register.
// RULE_19: Call loads target; returns pop, interrupt return sets I.
// RULE_20: Register and pair copy, one cycle, flags kept.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// Status flag bit positions
`define BSC_FLG_C 3'd0
`define BSC_FLG_Z 3'd1
`define BSC_FLG_N 3'd2
`define BSC_FLG_V 3'd3
`define BSC_FLG_S 3'd4
`define BSC_FLG_H 3'd5
`define BSC_FLG_T 3'd6
`define BSC_FLG_I 3'd7

// Fixed opcodes
`define BSC_OP_IND_CALL  16'h9509
`define BSC_OP_XIND_CALL 16'h9519
`define BSC_OP_SUB_RTN   16'h9508
`define BSC_OP_IRQ_RTN   16'h9518

// Masked opcode groups: mask, then match value
`define BSC_M_CALL  16'hfe0e
`define BSC_V_CALL  16'h940e
`define BSC_M_CMPX     16'hfc00
`define BSC_V_CMP_SKIP 16'h1000
`define BSC_V_CMP      16'h1400
`define BSC_V_CMP_C    16'h0400
`define BSC_M_CMP_I    16'hf000
`define BSC_V_CMP_I    16'h3000
`define BSC_M_RBIT     16'hfe08
`define BSC_V_RBIT_CLR 16'hfc00
`define BSC_V_RBIT_SET 16'hfe00
`define BSC_M_IOBIT    16'hff00
`define BSC_V_IOBIT_CLR 16'h9900
`define BSC_V_IOBIT_SET 16'h9b00
`define BSC_M_BRB      16'hfc00
`define BSC_V_BR_SET   16'hf000
`define BSC_V_BR_CLR   16'hf400
`define BSC_V_COPY     16'h2c00
`define BSC_M_COPYW    16'hff00
`define BSC_V_COPYW    16'h0100
`define BSC_M_W2JC  16'hfc0c
`define BSC_V_W2JC  16'h940c
`define BSC_M_W2LS  16'hfc0f
`define BSC_V_W2LS  16'h9000

// Cycle counts
`define BSC_LAT_ONE       3'd1
`define BSC_LAT_IND_CALL   3'd2
`define BSC_LAT_IND_CALL_W 3'd3
`define BSC_LAT_XIND_CALL  3'd3
`define BSC_LAT_CALL      3'd3
`define BSC_LAT_CALL_W    3'd4
`define BSC_LAT_RTN       3'd4
`define BSC_LAT_RTN_W     3'd5
`define BSC_LAT_IO_SKIP   3'd2
`define BSC_LAT_BR_TAKEN  3'd2

`endif

// ===== shared/bsc_pkg.sv
package bsc_pkg;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      BSC_IDLE = 2'b01,
      BSC_WAIT = 2'b10
   } bsc_state_e;

   // Instruction offered by fetch
   typedef struct packed {
      logic        valid;
      logic [15:0] op;
      logic [15:0] next_op;
   } bsc_instr_s;

   // Operand values read by the register file and I/O space
   typedef struct packed {
      logic [7:0] rd_val;
      logic [7:0] rr_val;
      logic [7:0] rr_hi;
      logic       io_bit;
   } bsc_opnd_s;

   // Core state seen by the decoder
   typedef struct packed {
      logic [21:0] pc;
      logic [15:0] z_ptr;
      logic [5:0]  ind_high;
      logic [7:0]  status_flag_reg;
      logic [21:0] stack_pc;
      logic        wide_pc;
   } bsc_core_s;

   // Compare flag set
   typedef struct packed {
      logic c;
      logic z;
      logic n;
      logic v;
      logic s;
      logic h;
   } bsc_flags_s;

   // Result of one instruction
   typedef struct packed {
      logic        done;
      logic        pc_jump;
      logic [21:0] pc_value;
      logic        flag_we;
      logic [7:0]  flag_value;
      logic        reg_we;
      logic        reg_pair;
      logic [4:0]  reg_idx;
      logic [15:0] reg_data;
      logic        push_we;
      logic [21:0] push_value;
      logic        pop_req;
      logic        unknown;
   } bsc_res_s;

   typedef struct packed {
      bsc_res_s   res;
      logic [2:0] lat;
   } bsc_dec_s;

   // All state of the control unit
   typedef struct packed {
      bsc_state_e state;
      logic [2:0] cnt;
      bsc_res_s   pend;
      bsc_res_s   out;
   } bsc_state_s;

endpackage : bsc_pkg

// ===== hw/bsc_compare.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"

module bsc_compare (
   input  wire logic [7:0]        a_val,
   input  wire logic [7:0]        b_val,
   input  wire logic              use_carry,
   input  wire logic [7:0]        status_flag_reg,
   output bsc_pkg::bsc_flags_s    flags
);
   import bsc_pkg::*;

   logic [7:0] diff;
   logic       cin;

   // Subtract only; the difference is never written back
   assign cin  = use_carry & status_flag_reg[`BSC_FLG_C];         // [RULE_18]
   assign diff = a_val - b_val - {7'h00, cin};                    // [RULE_18]

   // Flag equations of a subtraction
   always_comb begin
      flags.h = (~a_val[3] & b_val[3]) | (b_val[3] & diff[3]) | (diff[3] & ~a_val[3]);
      flags.c = (~a_val[7] & b_val[7]) | (b_val[7] & diff[7]) | (diff[7] & ~a_val[7]);
      flags.v = (a_val[7] & ~b_val[7] & ~diff[7]) | (~a_val[7] & b_val[7] & diff[7]);
      flags.n = diff[7];
      flags.s = diff[7] ^ flags.v;
      // With carry, zero is only kept or cleared, never set
      flags.z = (diff == 8'h00) & (~use_carry | status_flag_reg[`BSC_FLG_Z]); // [RULE_18]
   end

endmodule : bsc_compare
`default_nettype wire

// ===== hw/bsc_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"

module bsc_core (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire bsc_pkg::bsc_instr_s instr,
   input  wire bsc_pkg::bsc_opnd_s  opnd,
   input  wire bsc_pkg::bsc_core_s  core,
   output logic                   ready,
   output bsc_pkg::bsc_res_s      res
);
   import bsc_pkg::*;

   bsc_state_s s_r;
   bsc_state_s s_nxt;
   bsc_flags_s cmp_flags;
   logic [7:0] cmp_b;
   logic       use_cin_cmp;
   logic       imm_cmp;

   // Opcode group match
   function automatic logic op_is(input logic [15:0] op,
                                  input logic [15:0] mask,
                                  input logic [15:0] val);
      op_is = (op & mask) == val;
   endfunction : op_is

   // Length in words of the instruction that a skip jumps over
   function automatic logic [1:0] word_len(input logic [15:0] op);
      if (op_is(op, `BSC_M_W2JC, `BSC_V_W2JC) || op_is(op, `BSC_M_W2LS, `BSC_V_W2LS)) begin
         word_len = 2'd2;
      end else begin
         word_len = 2'd1;
      end
   endfunction : word_len

   // Selected status flag; the sign slot uses N xor V directly
   function automatic logic flag_pick(input logic [7:0] flg,
                                      input logic [2:0] idx);
      if (idx == `BSC_FLG_S) begin
         flag_pick = flg[`BSC_FLG_N] ^ flg[`BSC_FLG_V];           // [RULE_10] [RULE_11]
      end else begin
         flag_pick = flg[idx];                 // [RULE_12] [RULE_13] [RULE_14] [RULE_15]
      end                                                         // [RULE_16] [RULE_17]
   endfunction : flag_pick

   // Merge compare flags into the status byte, T and I kept
   function automatic logic [7:0] merge_flags(input logic [7:0] flg,
                                              input bsc_flags_s f);
      logic [7:0] m;
      m = flg;
      m[`BSC_FLG_C] = f.c;
      m[`BSC_FLG_Z] = f.z;
      m[`BSC_FLG_N] = f.n;
      m[`BSC_FLG_V] = f.v;
      m[`BSC_FLG_S] = f.s;
      m[`BSC_FLG_H] = f.h;
      merge_flags = m;
   endfunction : merge_flags

   // Decode one instruction into its result and cycle count
   function automatic bsc_dec_s decode(input bsc_instr_s in,
                                       input bsc_opnd_s  o,
                                       input bsc_core_s  c,
                                       input bsc_flags_s f);
      bsc_dec_s    d;
      logic [15:0] op;
      logic [21:0] fall;
      logic [21:0] koff;
      logic [1:0]  len;
      logic        skip_op;
      logic        skip;
      logic        cond;
      logic [2:0]  base;
      op      = in.op;
      d       = '0;
      d.lat   = `BSC_LAT_ONE;
      fall    = c.pc + 22'd1;
      koff    = {{15{op[9]}}, op[9:3]};
      len     = word_len(in.next_op);
      skip_op = 1'b0;
      skip    = 1'b0;
      base    = `BSC_LAT_ONE;
      cond    = 1'b0;
      d.res.done     = 1'b1;
      d.res.pc_value = fall;
      if (op == `BSC_OP_IND_CALL) begin
         d.res.pc_jump    = 1'b1;
         d.res.pc_value   = {6'h00, c.z_ptr};                           // [RULE_01]
         d.res.push_we    = 1'b1;
         d.res.push_value = fall;
         d.lat = c.wide_pc ? `BSC_LAT_IND_CALL_W : `BSC_LAT_IND_CALL; // [RULE_01]
      end else if (op == `BSC_OP_XIND_CALL) begin
         d.res.pc_jump    = 1'b1;
         d.res.pc_value   = {c.ind_high, c.z_ptr};                      // [RULE_02]
         d.res.push_we    = 1'b1;
         d.res.push_value = fall;
         d.lat = `BSC_LAT_XIND_CALL;                                  // [RULE_02]
      end else if (op_is(op, `BSC_M_CALL, `BSC_V_CALL)) begin
         d.res.pc_jump    = 1'b1;
         d.res.pc_value   = {op[8:4], op[0], in.next_op};               // [RULE_19]
         d.res.push_we    = 1'b1;
         d.res.push_value = c.pc + 22'd2;
         d.lat = c.wide_pc ? `BSC_LAT_CALL_W : `BSC_LAT_CALL;         // [RULE_19]
      end else if (op == `BSC_OP_SUB_RTN || op == `BSC_OP_IRQ_RTN) begin
         d.res.pc_jump  = 1'b1;
         d.res.pc_value = c.stack_pc;                                  // [RULE_19]
         d.res.pop_req  = 1'b1;
         d.lat = c.wide_pc ? `BSC_LAT_RTN_W : `BSC_LAT_RTN;           // [RULE_19]
         if (op == `BSC_OP_IRQ_RTN) begin
            d.res.flag_we    = 1'b1;
            d.res.flag_value = c.status_flag_reg | (8'h01 << `BSC_FLG_I); // [RULE_19]
         end
      end else if (op_is(op, `BSC_M_CMPX, `BSC_V_CMP_SKIP)) begin
         skip_op = 1'b1;
         skip    = o.rd_val == o.rr_val;                               // [RULE_03]
      end else if (op_is(op, `BSC_M_CMPX, `BSC_V_CMP) || op_is(op, `BSC_M_CMPX, `BSC_V_CMP_C)
                   || op_is(op, `BSC_M_CMP_I, `BSC_V_CMP_I)) begin
         d.res.flag_we    = 1'b1;
         d.res.flag_value = merge_flags(c.status_flag_reg, f);         // [RULE_18]
      end else if (op_is(op, `BSC_M_RBIT, `BSC_V_RBIT_CLR)) begin
         skip_op = 1'b1;
         skip    = ~o.rr_val[op[2:0]];                                 // [RULE_04]
      end else if (op_is(op, `BSC_M_RBIT, `BSC_V_RBIT_SET)) begin
         skip_op = 1'b1;
         skip    = o.rr_val[op[2:0]];                                  // [RULE_05]
      end else if (op_is(op, `BSC_M_IOBIT, `BSC_V_IOBIT_CLR)) begin
         skip_op = 1'b1;
         base    = `BSC_LAT_IO_SKIP;                                   // [RULE_06]
         skip    = ~o.io_bit;                                          // [RULE_06]
      end else if (op_is(op, `BSC_M_IOBIT, `BSC_V_IOBIT_SET)) begin
         skip_op = 1'b1;
         base    = `BSC_LAT_IO_SKIP;                                   // [RULE_07]
         skip    = o.io_bit;                                           // [RULE_07]
      end else if (op_is(op, `BSC_M_BRB, `BSC_V_BR_SET)
                   || op_is(op, `BSC_M_BRB, `BSC_V_BR_CLR)) begin
         // Bit 10 clear selects the set form
         cond = flag_pick(c.status_flag_reg, op[2:0]) ^ op[10];        // [RULE_08] [RULE_09]
         if (cond) begin
            d.res.pc_jump  = 1'b1;
            d.res.pc_value = fall + koff;                              // [RULE_08] [RULE_09]
            d.lat          = `BSC_LAT_BR_TAKEN;
         end
      end else if (op_is(op, `BSC_M_CMPX, `BSC_V_COPY)) begin
         d.res.reg_we   = 1'b1;
         d.res.reg_idx  = op[8:4];                                     // [RULE_20]
         d.res.reg_data = {8'h00, o.rr_val};                           // [RULE_20]
      end else if (op_is(op, `BSC_M_COPYW, `BSC_V_COPYW)) begin
         d.res.reg_we   = 1'b1;
         d.res.reg_pair = 1'b1;
         d.res.reg_idx  = {op[7:4], 1'b0};                             // [RULE_20]
         d.res.reg_data = {o.rr_hi, o.rr_val};                         // [RULE_20]
      end else begin
         d.res.unknown = 1'b1;
      end
      // Skips pass over one or two words and spend a cycle per word
      if (skip_op) begin
         d.lat = base;
         if (skip) begin
            d.res.pc_jump  = 1'b1;
            d.res.pc_value = fall + {20'h00000, len};        // [RULE_03] [RULE_04] [RULE_05]
            d.lat          = base + {1'b0, len};             // [RULE_06] [RULE_07]
         end
      end
      decode = d;
   endfunction : decode

   // Compare operand selection
   assign use_cin_cmp = op_is(instr.op, `BSC_M_CMPX, `BSC_V_CMP_C);
   assign imm_cmp     = op_is(instr.op, `BSC_M_CMP_I, `BSC_V_CMP_I);
   assign cmp_b       = imm_cmp ? {instr.op[11:8], instr.op[3:0]} : opnd.rr_val;

   bsc_compare u_compare (
      .a_val           (opnd.rd_val),
      .b_val           (cmp_b),
      .use_carry       (use_cin_cmp),
      .status_flag_reg (core.status_flag_reg),
      .flags     (cmp_flags)
   );

   // Accept, count the cycles, release the result on the last one
   always_comb begin
      bsc_dec_s d;
      d         = decode(instr, opnd, core, cmp_flags);
      s_nxt     = s_r;
      s_nxt.out = '0;
      case (s_r.state)
         BSC_IDLE: begin
            if (instr.valid) begin
               if (d.lat == `BSC_LAT_ONE) begin
                  s_nxt.out = d.res;                                   // [RULE_18] [RULE_20]
               end else begin
                  s_nxt.state = BSC_WAIT;
                  s_nxt.cnt   = d.lat - 3'd1;
                  s_nxt.pend  = d.res;
               end
            end
         end
         BSC_WAIT: begin
            s_nxt.cnt = s_r.cnt - 3'd1;
            if (s_r.cnt == 3'd1) begin
               s_nxt.out   = s_r.pend;
               s_nxt.state = BSC_IDLE;
               s_nxt.pend  = '0;
            end
         end
         default: begin
            s_nxt       = '0;
            s_nxt.state = BSC_IDLE;
         end
      endcase
   end

   // State register, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_r       <= '0;
         s_r.state <= BSC_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ready = rst_n && (s_r.state == BSC_IDLE); // Takes a new instruction
   assign res   = s_r.out;                          // Registered result

endmodule : bsc_core
`default_nettype wire

// ===== dv/bsc_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"

// Timing and result checks on the decoder ports
module bsc_core_asserts (
   input wire logic                ref_clk,
   input wire logic                rst_n,
   input wire bsc_pkg::bsc_instr_s instr,
   input wire bsc_pkg::bsc_opnd_s  opnd,
   input wire bsc_pkg::bsc_core_s  core,
   input wire logic                ready,
   input wire bsc_pkg::bsc_res_s   res
);
   import bsc_pkg::*;
   logic take;
   // Instruction accepted at this edge
   assign take = instr.valid && ready;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_IND_CALL_NARROW: assert property (take && instr.op == `BSC_OP_IND_CALL
      && !core.wide_pc
      |=> !ready && !res.done ##1 res.done && res.pc_value == {6'h00, $past(core.z_ptr, 2)})
      else $error("indirect call target or timing wrong");
   AST_XIND_CALL_HIGH: assert property (take && instr.op == `BSC_OP_XIND_CALL
      |=> !res.done [*2] ##1 res.done && res.pc_value[21:16] == $past(core.ind_high, 3))
      else $error("extended call high bits or timing wrong");
   AST_BR_SET_TAKEN: assert property (take && (instr.op & `BSC_M_BRB) == `BSC_V_BR_SET &&
      instr.op[2:0] != 3'h4 && core.status_flag_reg[instr.op[2:0]]
      |=> !res.done ##1 res.done && res.pc_jump)
      else $error("flag set branch not taken in two cycles");
   AST_BR_CLR_FALL: assert property (take && (instr.op & `BSC_M_BRB) == `BSC_V_BR_CLR &&
      instr.op[2:0] != 3'h4 && core.status_flag_reg[instr.op[2:0]]
      |=> res.done && !res.pc_jump && res.pc_value == $past(core.pc) + 22'h000001)
      else $error("flag clear branch did not fall through");
   AST_SIGNED_GE: assert property (take && (instr.op & `BSC_M_BRB) == `BSC_V_BR_CLR &&
      instr.op[2:0] == 3'h4 && !(core.status_flag_reg[2] ^ core.status_flag_reg[3])
      |=> ##1 res.done && res.pc_jump)
      else $error("signed ge branch not taken");
   AST_CMP_NO_WRITE: assert property (take && (instr.op & `BSC_M_CMPX) == `BSC_V_CMP
      |=> res.done && res.flag_we && !res.reg_we)
      else $error("compare wrote a register");
   AST_COPY_ONE: assert property (take && (instr.op & `BSC_M_CMPX) == `BSC_V_COPY
      |=> res.done && res.reg_we && !res.flag_we && res.reg_data[7:0] == $past(opnd.rr_val))
      else $error("register copy wrong");
   AST_COPY_PAIR: assert property (take && (instr.op & `BSC_M_COPYW) == `BSC_V_COPYW
      |=> res.done && res.reg_pair && res.reg_data == {$past(opnd.rr_hi), $past(opnd.rr_val)})
      else $error("pair copy wrong");
   AST_IRQ_RTN_SET_I: assert property (take && instr.op == `BSC_OP_IRQ_RTN
      && !core.wide_pc
      |=> !res.done [*3] ##1 res.done && res.pop_req && res.flag_value[7])
      else $error("interrupt return wrong");
   // Main scenarios reached
   cover property (take && instr.op == `BSC_OP_XIND_CALL);
   cover property (take && (instr.op & `BSC_M_BRB) == `BSC_V_BR_SET);
   cover property (take && (instr.op & `BSC_M_COPYW) == `BSC_V_COPYW);
endmodule : bsc_core_asserts

bind bsc_core bsc_core_asserts bsc_core_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
   .instr(instr), .opnd(opnd), .core(core), .ready(ready), .res(res));
`default_nettype wire

// ===== dv/bsc_opnd_model.sv
`timescale 1ns/100ps
`default_nettype none

// Register file and I/O bits answering the operand fields of an opcode
module bsc_opnd_model (
   input  wire logic [15:0]   op,
   output bsc_pkg::bsc_opnd_s opnd
);
   import bsc_pkg::*;
   logic [7:0] regs    [32];
   logic [7:0] io_bits [32];
   logic [4:0] rd_idx;
   logic [4:0] rr_idx;
   // Field positions differ per opcode group
   always_comb begin
      rd_idx = op[8:4];
      rr_idx = {op[9], op[3:0]};
      if (op[15:12] == 4'h3) rd_idx = {1'h1, op[7:4]};  // Immediate compare uses upper half
      if (op[15:8] == 8'h01) rr_idx = {op[3:0], 1'h0};  // Pair source is even
      if (op[15:10] == 6'h3f) rr_idx = op[8:4];  // Bit skip tests this register
      opnd.rd_val = regs[rd_idx];
      opnd.rr_val = regs[rr_idx];
      opnd.rr_hi  = regs[rr_idx + 5'h01];
      opnd.io_bit = io_bits[op[7:3]][op[2:0]];
   end
endmodule : bsc_opnd_model
`default_nettype wire

// ===== dv/bsc_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
`define BSC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module bsc_core_tb;
   import bsc_pkg::*;
   logic       ref_clk;
   logic       rst_n;
   bsc_instr_s instr;
   bsc_core_s  core;
   bsc_opnd_s  opnd;
   logic       ready;
   bsc_res_s   res;
   bsc_res_s   got;
   int         lat;
   int         error_cnt;
   int         cmp_count;

   bsc_core bsc_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .opnd(opnd),
      .core(core), .ready(ready), .res(res));
   bsc_opnd_model bsc_opnd_model_inst (.op(instr.op), .opnd(opnd));

   // Offer one instruction, then count cycles until its result
   task automatic exec(input logic [15:0] op, input logic [15:0] nxt);
      @(negedge ref_clk);
      instr.valid = 1'h1;
      instr.op = op;
      instr.next_op = nxt;
      @(negedge ref_clk);
      instr.valid = 1'h0;
      lat = 1;
      while (res.done !== 1'h1 && lat < 8) begin
         @(negedge ref_clk);
         lat++;
      end
      got = res;
   endtask : exec

   // Calls and returns in both program counter widths
   task automatic t_calls();
      for (int w = 0; w < 2; w++) begin
         core.wide_pc = w[0];
         core.status_flag_reg = 8'h01;
         exec(`BSC_OP_IND_CALL, 16'h0000);
         `BSC_CHK(lat, 2 + w)
         `BSC_CHK(got.pc_value, 22'h001234)
         exec(`BSC_OP_XIND_CALL, 16'h0000);
         `BSC_CHK(lat, 3)
         `BSC_CHK(got.pc_value, 22'h2a1234)
         exec(16'h941f, 16'h5678);
         `BSC_CHK(lat, 3 + w)
         `BSC_CHK({got.pc_value, got.push_we, got.push_value}, {22'h035678, 1'h1, 22'h000102})
         exec(`BSC_OP_IRQ_RTN, 16'h0000);
         `BSC_CHK(lat, 4 + w)
         `BSC_CHK({got.pc_value, got.pop_req, got.flag_we, got.flag_value}, {22'h0abcde, 2'h3, 8'h81})
         exec(`BSC_OP_SUB_RTN, 16'h0000);
         `BSC_CHK(lat, 4 + w)
         `BSC_CHK({got.pc_value, got.pop_req, got.flag_we}, {22'h0abcde, 2'h2})
      end
      core.wide_pc = 1'h0;
   endtask : t_calls

   // Compares: flags only, and the equal skip
   task automatic t_compare();
      bsc_opnd_model_inst.regs[16] = 8'h10;
      bsc_opnd_model_inst.regs[17] = 8'h20;
      core.status_flag_reg = 8'hc0;
      exec(16'h1701, 16'h0000);
      `BSC_CHK({got.flag_we, got.flag_value, got.reg_we}, {1'h1, 8'hd5, 1'h0})
      bsc_opnd_model_inst.regs[16] = 8'h42;
      bsc_opnd_model_inst.regs[17] = 8'h41;
      core.status_flag_reg = 8'h01;
      exec(16'h0701, 16'h0000);
      `BSC_CHK({got.flag_we, got.flag_value, got.reg_we}, {1'h1, 8'h00, 1'h0})
      exec(16'h3402, 16'h0000);
      `BSC_CHK({lat[1:0], got.flag_value, got.reg_we}, {2'h1, 8'h02, 1'h0})
      exec(16'h1301, 16'h940e);
      `BSC_CHK({lat[1:0], got.pc_jump, got.pc_value}, {2'h1, 1'h0, 22'h000101})
      bsc_opnd_model_inst.regs[17] = 8'h42;
      exec(16'h1301, 16'h940e);
      `BSC_CHK({lat[1:0], got.pc_value}, {2'h3, 22'h000103})
   endtask : t_compare

   // Bit skips over one- and two-word instructions
   task automatic t_skips();
      logic [15:0] ops [4] = '{16'hfd03, 16'hff03, 16'h992a, 16'h9b2a};
      logic [15:0] nxt [2] = '{16'h0000, 16'h940e};
      int          skip;
      for (int i = 0; i < 4; i++) begin
         for (int v = 0; v < 4; v++) begin
            bsc_opnd_model_inst.regs[16] = v[1] ? 8'h08 : 8'hf7;
            bsc_opnd_model_inst.io_bits[5] = v[1] ? 8'h04 : 8'hfb;
            skip = (v[1] == i[0]) ? v[0] + 1 : 0;
            exec(ops[i], nxt[v[0]]);
            `BSC_CHK(lat, i / 2 + 1 + skip)
            `BSC_CHK(got.pc_value, 22'h000101 + 22'(skip))
         end
      end
   endtask : t_skips

   // Every flag slot, set and clear forms, with the live sign slot
   task automatic t_branches();
      logic [7:0] pat [3];
      logic       taken;
      for (int f = 0; f < 2; f++) begin
         for (int s = 0; s < 8; s++) begin
            pat = '{8'h01 << s, ~(8'h01 << s), 8'h04};
            for (int p = 0; p < 3; p++) begin
               core.status_flag_reg = pat[p];
               taken = ((s == 4) ? pat[p][2] ^ pat[p][3] : pat[p][s]) ^ f[0];
               exec(16'hf3e8 | 16'(f << 10) | 16'(s), 16'h0000);
               `BSC_CHK(lat, taken + 1)
               `BSC_CHK({got.pc_jump, got.pc_value}, {taken, taken ? 22'h0000fe : 22'h000101})
            end
         end
      end
   endtask : t_branches

   // Register copies leave flags alone; foreign opcode flagged
   task automatic t_copy();
      core.status_flag_reg = 8'h5a;
      exec(16'h2f41, 16'h0000);
      `BSC_CHK({lat[1:0], got.reg_idx, got.reg_data, got.flag_we}, {2'h1, 5'h14, 16'h0042, 1'h0})
      // Source pair is r17:r16, r16 last left at 08 by the bit skips
      exec(16'h0128, 16'h0000);
      `BSC_CHK({lat[1:0], got.reg_pair, got.reg_idx, got.reg_data}, {2'h1, 1'h1, 5'h04, 16'h4208})
      exec(16'h0c00, 16'h0000);
      `BSC_CHK({lat[1:0], got.unknown, got.reg_we}, {2'h1, 1'h1, 1'h0})
   endtask : t_copy

   // Print the counts and the verdict, then stop
   task automatic complete_run();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Clock at 25 MHz
   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Watchdog well beyond the expected run
   initial begin
      #200000;
      error_cnt++;
      complete_run();
   end

   // Reset, then all scenarios
   initial begin
      rst_n = 1'h0;
      instr = '0;
      core = '0;
      core.pc = 22'h000100;
      core.z_ptr = 16'h1234;
      core.ind_high = 6'h2a;
      core.stack_pc = 22'h0abcde;
      for (int i = 0; i < 32; i++) begin
         bsc_opnd_model_inst.regs[i] = 8'(i);
         bsc_opnd_model_inst.io_bits[i] = 8'h00;
      end
      repeat (10) @(negedge ref_clk);
      `BSC_CHK({ready, res}, '0)
      rst_n = 1'h1;
      t_calls();
      t_compare();
      t_skips();
      t_branches();
      t_copy();
      complete_run();
   end
endmodule : bsc_core_tb
`default_nettype wire
